// [param_channel_error_and_page_index.sv]
// parameter channel request checker with page index decode
`timescale 1ns/10ps
`include "pchan_regs.svh"
module param_channel_error_and_page_index #(
  parameter int LOOKUP_CYCLES = `LOOKUP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire pchan_pkg::chan_t req,
  output logic req_ready_q,
  output logic lookup_valid_q,
  output logic [15:0] lookup_num_q,
  output logic [7:0] lookup_sub_q,
  output logic [31:0] lookup_val_q,
  input wire logic attr_valid,
  input wire pchan_pkg::attr_t attr,
  output logic commit_q,
  output logic [31:0] commit_val_q,
  output logic resp_valid_q,
  output pchan_pkg::chan_t resp_q,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_q
);

  localparam int TW = $clog2(LOOKUP_CYCLES + 1);

  // ==========================================================
  // page index decode
  // ==========================================================

  // map a page code to its offset, unknown codes flagged
  function automatic pchan_pkg::page_t page_decode(input logic [7:0] pg);
    pchan_pkg::page_t p;
    p.ok = 1'b1;
    p.off = 16'h0000;
    case (pg)
      `PAGE_0: p.off = 16'h0000;
      `PAGE_2000: p.off = `OFF_2000;
      `PAGE_6000: p.off = `OFF_6000;
      `PAGE_8000: p.off = `OFF_8000;
      `PAGE_10000: p.off = `OFF_10000;
      `PAGE_20000: p.off = `OFF_20000;
      `PAGE_30000: p.off = `OFF_30000;
      `PAGE_60000: p.off = `OFF_60000;
      default: p.ok = 1'b0;
    endcase
    return p;
  endfunction

  // ==========================================================
  // declarations
  // ==========================================================

  pchan_pkg::state_t state_q, state_d;
  pchan_pkg::chan_t chan_q, chan_d;
  pchan_pkg::chan_t resp_d;
  logic [TW-1:0] tmo_q, tmo_d;
  logic req_ready_d;
  logic lookup_valid_d;
  logic [15:0] lookup_num_d;
  logic [7:0] lookup_sub_d;
  logic [31:0] lookup_val_d;
  logic commit_d;
  logic [31:0] commit_val_d;
  logic resp_valid_d;
  logic done;
  logic done_err;

  logic [6:0] ctrl_q, ctrl_d;
  logic [7:0] comm_sel_q, comm_sel_d;
  logic [15:0] err_cnt_q, err_cnt_d;
  logic [15:0] req_cnt_q, req_cnt_d;
  logic [12:0] last_q, last_d;
  logic [15:0] reg_rdata_d;

  // decode of the incoming request
  pchan_pkg::page_t in_page;
  logic [3:0] in_rq;
  logic [15:0] in_num;
  logic in_supported;
  logic pre_hit;
  pchan_pkg::err_t pre_err;

  // decode of the latched request against attributes
  logic [3:0] rq;
  logic [7:0] sub;
  logic is_field;
  logic is_read;
  logic is_desc;
  logic is_count;
  logic chg_w;
  logic chg_d;
  logic chg;
  logic [31:0] val;
  logic post_hit;
  pchan_pkg::err_t post_err;
  logic [3:0] pos_code;
  logic [15:0] pos_w2;
  logic [15:0] pos_w3;

  // ==========================================================
  // checks before the parameter lookup
  // ==========================================================

  // cheap checks on the raw request; a failing one skips the lookup
  always_comb begin
    in_page = page_decode(req.w1[`PAGE_MSB:0]);
    in_rq = req.w0[`RC_MSB:`RC_LSB];
    // offset chosen by the page code
    in_num = in_page.off + {5'h00, req.w0[`NUM_MSB:0]};
    in_supported = 1'b0;
    case (in_rq)
      pchan_pkg::RQ_NONE, pchan_pkg::RQ_READ, pchan_pkg::RQ_CHG_W,
      pchan_pkg::RQ_CHG_D, pchan_pkg::RQ_DESC, pchan_pkg::RQ_FREAD,
      pchan_pkg::RQ_FCHG_W, pchan_pkg::RQ_FCHG_D,
      pchan_pkg::RQ_COUNT: in_supported = 1'b1;
      default: in_supported = 1'b0;
    endcase
    pre_hit = 1'b1;
    pre_err = pchan_pkg::E_NO_PARAM;
    if (!in_supported) begin
      pre_err = pchan_pkg::E_UNSUPP;
    end else if (ctrl_q[`CTRL_KNOWHOW]) begin
      pre_err = pchan_pkg::E_KNOWHOW;
    // unknown page or field too big
    end else if (!in_page.ok || req.w0[`NUM_MSB:0] >= `NUM_SPAN) begin
      pre_err = pchan_pkg::E_NO_PARAM;
    end else begin
      pre_hit = 1'b0;
    end
  end

  // ==========================================================
  // checks against the parameter attributes
  // ==========================================================

  always_comb begin
    rq = chan_q.w0[`RC_MSB:`RC_LSB];
    sub = chan_q.w1[`SUB_MSB:`SUB_LSB];
    is_field = (rq >= pchan_pkg::RQ_FREAD) && (rq != pchan_pkg::RQ_COUNT);
    is_read = (rq == pchan_pkg::RQ_READ) || (rq == pchan_pkg::RQ_FREAD);
    is_desc = (rq == pchan_pkg::RQ_DESC);
    is_count = (rq == pchan_pkg::RQ_COUNT);
    chg_w = (rq == pchan_pkg::RQ_CHG_W) || (rq == pchan_pkg::RQ_FCHG_W);
    chg_d = (rq == pchan_pkg::RQ_CHG_D) || (rq == pchan_pkg::RQ_FCHG_D);
    chg = chg_w || chg_d;
    // a word change carries its value in the low word only
    val = chg_d ? {chan_q.w2, chan_q.w3} : {16'h0000, chan_q.w3};
    post_hit = 1'b1;
    post_err = pchan_pkg::E_NO_PARAM;
    if (!attr.exists) begin
      post_err = pchan_pkg::E_NO_PARAM;
    end else if (attr.deactivated) begin
      post_err = pchan_pkg::E_DEACT;
    end else if (ctrl_q[`CTRL_OP_BUSY]) begin
      post_err = pchan_pkg::E_OP_STATE;
    end else if (!attr.indexed && (sub != 8'h00 || is_count)) begin
      post_err = pchan_pkg::E_NO_ARRAY;
    end else if (attr.indexed && !is_count && sub >= attr.sub_count) begin
      post_err = pchan_pkg::E_SUBINDEX;
    end else if (chg && attr.desc_fixed) begin
      post_err = pchan_pkg::E_DESC_FIXED;
    end else if (chg && attr.read_only) begin
      post_err = pchan_pkg::E_RO;
    end else if (chg && !ctrl_q[`CTRL_MASTER]) begin
      post_err = pchan_pkg::E_NO_MASTER;
    end else if (chg && attr.commission_only && comm_sel_q != `COMMISSION_VAL) begin
      post_err = pchan_pkg::E_COMMISSION;
    end else if (chg && attr.loop_locked && ctrl_q[`CTRL_LOOP_EN]) begin
      post_err = pchan_pkg::E_LOOP;
    end else if (chg && attr.needs_code && !ctrl_q[`CTRL_CODE_OK]) begin
      post_err = pchan_pkg::E_ACCESS_CODE;
    end else if (chg && (chg_d != attr.is_dword)) begin
      post_err = pchan_pkg::E_TYPE;
    end else if (chg && attr.reset_only && val != 32'h0000_0000
                 && !ctrl_q[`CTRL_RESET_PERM]) begin
      post_err = pchan_pkg::E_RESET_ONLY;
    end else if (chg && (val < attr.abs_min || val > attr.abs_max)) begin
      post_err = pchan_pkg::E_LIMIT;
    end else if (chg && val < attr.cur_min) begin
      post_err = pchan_pkg::E_BELOW;
    end else if (chg && val > attr.cur_max) begin
      post_err = pchan_pkg::E_ABOVE;
    end else if (chg && attr.discrete && !attr.listed) begin
      post_err = pchan_pkg::E_INADMISSIBLE;
    end else if (chg && (val & ~attr.value_mask) != 32'h0000_0000) begin
      post_err = pchan_pkg::E_ILLEGAL_VAL;
    end else if ((is_read || is_desc) && attr.is_dword && ctrl_q[`CTRL_NARROW]) begin
      post_err = pchan_pkg::E_CHANNEL;
    end else begin
      post_hit = 1'b0;
    end
  end

  // positive answer code and value words
  always_comb begin
    pos_code = pchan_pkg::RSP_WORD;
    pos_w2 = 16'h0000;
    pos_w3 = attr.value[15:0];
    if (is_count) begin
      pos_code = pchan_pkg::RSP_COUNT;
      pos_w3 = {8'h00, attr.sub_count};
    end else if (is_desc) begin
      pos_code = pchan_pkg::RSP_DESC;
      pos_w2 = attr.is_dword ? attr.value[31:16] : 16'h0000;
    end else if (chg) begin
      // a change echoes the value it wrote
      pos_code = chg_d ? pchan_pkg::RSP_DWORD : pchan_pkg::RSP_WORD;
      pos_w2 = chan_q.w2;
      pos_w3 = chan_q.w3;
    end else if (attr.is_dword) begin
      pos_code = pchan_pkg::RSP_DWORD;
      pos_w2 = attr.value[31:16];
    end
    if (is_field && pos_code == pchan_pkg::RSP_WORD) begin
      pos_code = pchan_pkg::RSP_FWORD;
    end else if (is_field && pos_code == pchan_pkg::RSP_DWORD) begin
      pos_code = pchan_pkg::RSP_FDWORD;
    end
  end

  // ==========================================================
  // request sequencer
  // ==========================================================

  // one request in flight; the lookup is never overlapped
  always_comb begin
    state_d = state_q;
    chan_d = chan_q;
    tmo_d = tmo_q;
    req_ready_d = req_ready_q;
    lookup_valid_d = 1'b0;
    lookup_num_d = lookup_num_q;
    lookup_sub_d = lookup_sub_q;
    lookup_val_d = lookup_val_q;
    commit_d = 1'b0;
    commit_val_d = commit_val_q;
    resp_valid_d = 1'b0;
    resp_d = resp_q;
    done = 1'b0;
    done_err = 1'b0;
    case (state_q)
      pchan_pkg::S_IDLE: begin
        if (req_valid && req_ready_q) begin
          chan_d = req;
          if (pre_hit) begin
            resp_d.w0 = {pchan_pkg::RSP_ERR, 1'b0, req.w0[`NUM_MSB:0]};
            resp_d.w1 = req.w1;
            resp_d.w2 = {8'h00, pre_err};
            resp_d.w3 = 16'h0000;
            resp_valid_d = 1'b1;
            done = 1'b1;
            done_err = 1'b1;
          end else if (in_rq == pchan_pkg::RQ_NONE) begin
            // no request: no response, channel cleared
            resp_d = '0;
            resp_valid_d = 1'b1;
            done = 1'b1;
          end else begin
            lookup_valid_d = 1'b1;
            lookup_num_d = in_num;
            lookup_sub_d = req.w1[`SUB_MSB:`SUB_LSB];
            lookup_val_d = (in_rq == pchan_pkg::RQ_CHG_D || in_rq == pchan_pkg::RQ_FCHG_D)
                           ? {req.w2, req.w3} : {16'h0000, req.w3};
            tmo_d = '0;
            req_ready_d = 1'b0;
            state_d = pchan_pkg::S_LOOKUP;
          end
        end
      end
      pchan_pkg::S_LOOKUP: begin
        // the old answer stands until this one is ready
        if (attr_valid) begin
          state_d = pchan_pkg::S_IDLE;
          req_ready_d = 1'b1;
          resp_valid_d = 1'b1;
          resp_d.w1 = chan_q.w1;
          done = 1'b1;
          if (post_hit) begin
            resp_d.w0 = {pchan_pkg::RSP_ERR, 1'b0, chan_q.w0[`NUM_MSB:0]};
            resp_d.w2 = {8'h00, post_err};
            resp_d.w3 = 16'h0000;
            done_err = 1'b1;
          end else begin
            resp_d.w0 = {pos_code, 1'b0, chan_q.w0[`NUM_MSB:0]};
            resp_d.w2 = pos_w2;
            resp_d.w3 = pos_w3;
            commit_d = chg;
            commit_val_d = chg ? val : commit_val_q;
          end
        end else if (tmo_q == TW'(LOOKUP_CYCLES - 1)) begin
          // silent database treated as a temporary block
          // lookup timed out
          state_d = pchan_pkg::S_IDLE;
          req_ready_d = 1'b1;
          resp_d.w0 = {pchan_pkg::RSP_ERR, 1'b0, chan_q.w0[`NUM_MSB:0]};
          resp_d.w1 = chan_q.w1;
          resp_d.w2 = {8'h00, pchan_pkg::E_OP_STATE};
          resp_d.w3 = 16'h0000;
          resp_valid_d = 1'b1;
          done = 1'b1;
          done_err = 1'b1;
        end else begin
          tmo_d = tmo_q + TW'(1);
        end
      end
      default: begin
        state_d = pchan_pkg::S_IDLE;
        req_ready_d = 1'b1;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= pchan_pkg::S_IDLE;
      chan_q <= '0;
      tmo_q <= '0;
      req_ready_q <= 1'b1;
      lookup_valid_q <= 1'b0;
      lookup_num_q <= 16'h0000;
      lookup_sub_q <= 8'h00;
      lookup_val_q <= 32'h0000_0000;
      commit_q <= 1'b0;
      commit_val_q <= 32'h0000_0000;
      resp_valid_q <= 1'b0;
      resp_q <= '0;
    end else begin
      state_q <= state_d;
      chan_q <= chan_d;
      tmo_q <= tmo_d;
      req_ready_q <= req_ready_d;
      lookup_valid_q <= lookup_valid_d;
      lookup_num_q <= lookup_num_d;
      lookup_sub_q <= lookup_sub_d;
      lookup_val_q <= lookup_val_d;
      commit_q <= commit_d;
      commit_val_q <= commit_val_d;
      resp_valid_q <= resp_valid_d;
      resp_q <= resp_d;
    end
  end

  // ==========================================================
  // register port
  // ==========================================================

  // writes, counters and read mux; a same-cycle event is counted on top of a clear
  always_comb begin
    ctrl_d = ctrl_q;
    comm_sel_d = comm_sel_q;
    err_cnt_d = err_cnt_q;
    req_cnt_d = req_cnt_q;
    last_d = last_q;
    reg_rdata_d = 16'h0000;
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_CTRL: ctrl_d = reg_wdata[6:0];
        `ADDR_COMM_SEL: comm_sel_d = reg_wdata[7:0];
        `ADDR_ERR_CNT: err_cnt_d = 16'h0000;
        `ADDR_REQ_CNT: req_cnt_d = 16'h0000;
        default: ctrl_d = ctrl_q;
      endcase
    end
    // counters stick at full scale rather than wrap
    if (done && req_cnt_d != 16'hFFFF) begin
      req_cnt_d = req_cnt_d + 16'h0001;
    end
    if (done_err && err_cnt_d != 16'hFFFF) begin
      err_cnt_d = err_cnt_d + 16'h0001;
    end
    if (done) begin
      last_d = {done_err, resp_d.w0[`RC_MSB:`RC_LSB], resp_d.w2[7:0]};
    end
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_CTRL: reg_rdata_d = {9'h000, ctrl_q};
        `ADDR_COMM_SEL: reg_rdata_d = {8'h00, comm_sel_q};
        `ADDR_STATUS: reg_rdata_d = {14'h0000, last_q[12], state_q != pchan_pkg::S_IDLE};
        `ADDR_LAST: reg_rdata_d = {4'h0, last_q[11:0]};
        `ADDR_ERR_CNT: reg_rdata_d = err_cnt_q;
        `ADDR_REQ_CNT: reg_rdata_d = req_cnt_q;
        default: reg_rdata_d = 16'h0000;
      endcase
    end
  end

  // register file state
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= `CTRL_RESET;
      comm_sel_q <= `COMM_SEL_RESET;
      err_cnt_q <= 16'h0000;
      req_cnt_q <= 16'h0000;
      last_q <= 13'h0000;
      reg_rdata_q <= 16'h0000;
    end else begin
      ctrl_q <= ctrl_d;
      comm_sel_q <= comm_sel_d;
      err_cnt_q <= err_cnt_d;
      req_cnt_q <= req_cnt_d;
      last_q <= last_d;
      reg_rdata_q <= reg_rdata_d;
    end
  end

endmodule

// [pchan_regs.svh]
// constants for the parameter channel checker: offsets, fields, resets, timing
// Function
// - unserviceable request answers response code 7 with error number in upper value word
// - response code in bits 15..12 of first word, bit 11 always zero
// - nonexistent parameter number gives error 0x00
// - change of an unchangeable parameter gives error 0x01
// - change value outside lower or upper limit gives error 0x02
// - missing subindex gives 0x03, subindex on non-indexed parameter gives 0x04
// - change value of wrong data type gives error 0x05
// - nonzero write to reset-only parameter without permission gives 0x06
// - change of a fixed descriptive element gives error 0x07
// - change without master control gives error 0x0B
// - operating state temporarily blocking the request gives error 0x11
// - value within limits but not a permitted individual value gives 0x14
// - parameter deactivated in current mode gives error 0x65
// - channel too narrow for the response gives error 0x66
// - value not among the values the parameter may assume gives 0x68
// - unsupported request identifier gives error 0x6A
// - change while closed-loop controller enabled gives error 0x6B
// - commissioning-only write while selector is not 15 gives 0x86
// - any supported request while know-how protection is active gives 0x87
// - below current lower limit gives 0xC8, above current upper gives 0xC9
// - change without available access code gives error 0xCC
// - numbers below 2000 go directly in number field, page index zero
// - larger numbers carry number minus offset, offset code in index bits 7..0
// - page codes 00,80,90,20,A0,50,F0,74 for the eight offsets, span 2000
`ifndef PCHAN_REGS_SVH
`define PCHAN_REGS_SVH
// register offsets
`define ADDR_CTRL 4'h0
`define ADDR_COMM_SEL 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_LAST 4'h3
`define ADDR_ERR_CNT 4'h4
`define ADDR_REQ_CNT 4'h5
// control bits
`define CTRL_MASTER 0
`define CTRL_KNOWHOW 1
`define CTRL_LOOP_EN 2
`define CTRL_OP_BUSY 3
`define CTRL_CODE_OK 4
`define CTRL_RESET_PERM 5
`define CTRL_NARROW 6
`define CTRL_RESET 7'h01
`define COMM_SEL_RESET 8'h00
`define COMMISSION_VAL 8'h0F
// channel word fields
`define RC_MSB 15
`define RC_LSB 12
`define NUM_MSB 10
`define SUB_MSB 15
`define SUB_LSB 8
`define PAGE_MSB 7
`define NUM_SPAN 11'h7D0
// page index codes and offsets
`define PAGE_0 8'h00
`define PAGE_2000 8'h80
`define PAGE_6000 8'h90
`define PAGE_8000 8'h20
`define PAGE_10000 8'hA0
`define PAGE_20000 8'h50
`define PAGE_30000 8'hF0
`define PAGE_60000 8'h74
`define OFF_2000 16'h07D0
`define OFF_6000 16'h1770
`define OFF_8000 16'h1F40
`define OFF_10000 16'h2710
`define OFF_20000 16'h4E20
`define OFF_30000 16'h7530
`define OFF_60000 16'hEA60
// lookup timeout, longest time rounded down
`define LOOKUP_TIMEOUT_NS 800
`define CLK_PERIOD_NS 50
`define LOOKUP_CYCLES (`LOOKUP_TIMEOUT_NS / `CLK_PERIOD_NS)
`endif

// [pchan_pkg.sv]
// types shared by the parameter channel checker
package pchan_pkg;
  typedef enum logic [3:0] {
    RQ_NONE = 4'h0, RQ_READ = 4'h1, RQ_CHG_W = 4'h2, RQ_CHG_D = 4'h3,
    RQ_DESC = 4'h4, RQ_FREAD = 4'h6, RQ_FCHG_W = 4'h7, RQ_FCHG_D = 4'h8,
    RQ_COUNT = 4'h9
  } req_id_t;
  typedef enum logic [3:0] {
    RSP_NONE = 4'h0, RSP_WORD = 4'h1, RSP_DWORD = 4'h2, RSP_DESC = 4'h3,
    RSP_FWORD = 4'h4, RSP_FDWORD = 4'h5, RSP_COUNT = 4'h6, RSP_ERR = 4'h7
  } resp_id_t;
  typedef enum logic [7:0] {
    E_NO_PARAM = 8'h00, E_RO = 8'h01, E_LIMIT = 8'h02, E_SUBINDEX = 8'h03,
    E_NO_ARRAY = 8'h04, E_TYPE = 8'h05, E_RESET_ONLY = 8'h06, E_DESC_FIXED = 8'h07,
    E_NO_MASTER = 8'h0B, E_OP_STATE = 8'h11, E_INADMISSIBLE = 8'h14,
    E_DEACT = 8'h65, E_CHANNEL = 8'h66, E_ILLEGAL_VAL = 8'h68, E_UNSUPP = 8'h6A,
    E_LOOP = 8'h6B, E_COMMISSION = 8'h86, E_KNOWHOW = 8'h87, E_BELOW = 8'hC8,
    E_ABOVE = 8'hC9, E_ACCESS_CODE = 8'hCC
  } err_t;
  typedef enum logic [0:0] {S_IDLE, S_LOOKUP} state_t;
  typedef struct packed {
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] w2;
    logic [15:0] w3;
  } chan_t;
  typedef struct packed {
    logic exists;
    logic deactivated;
    logic read_only;
    logic indexed;
    logic [7:0] sub_count;
    logic is_dword;
    logic reset_only;
    logic commission_only;
    logic loop_locked;
    logic needs_code;
    logic desc_fixed;
    logic discrete;
    logic listed;
    logic [31:0] value;
    logic [31:0] abs_min;
    logic [31:0] abs_max;
    logic [31:0] cur_min;
    logic [31:0] cur_max;
    logic [31:0] value_mask;
  } attr_t;
  typedef struct packed {
    logic ok;
    logic [15:0] off;
  } page_t;
endpackage

// [pchan_db_model.sv]
// parameter database stand-in answering attribute lookups
`timescale 1ns/10ps
module pchan_db_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic lookup_valid_q,
  input wire pchan_pkg::attr_t cfg,
  input wire logic [4:0] dly,
  output logic attr_valid,
  output pchan_pkg::attr_t attr
);
  logic busy_q;
  logic [4:0] cnt_q;
  // ==========
  // answer after dly cycles; 0 same cycle, 31 never (forces a timeout)
  assign attr_valid = dly != 5'h1F && (lookup_valid_q ? dly == 5'h00 : busy_q && cnt_q == dly);
  // outside the answer cycle show the inverse, never a stale copy
  assign attr = attr_valid ? cfg : ~cfg;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      cnt_q <= 5'h00;
    end else if (attr_valid) begin
      busy_q <= 1'b0;
    end else if (lookup_valid_q) begin
      busy_q <= 1'b1;
      cnt_q <= 5'h01;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
endmodule

// [pchan_sva.sv]
// concurrent checks on the parameter channel checker ports
`timescale 1ns/10ps
module pchan_sva #(
  parameter int LOOKUP_CYCLES = 16
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire pchan_pkg::chan_t req,
  input wire logic req_ready_q,
  input wire logic lookup_valid_q,
  input wire logic [15:0] lookup_num_q,
  input wire logic [31:0] lookup_val_q,
  input wire logic attr_valid,
  input wire logic commit_q,
  input wire logic [31:0] commit_val_q,
  input wire logic resp_valid_q,
  input wire pchan_pkg::chan_t resp_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] wait_q;
  logic [7:0] wait_d;
  // ==========
  // helper: cycles spent without an answer
  always_comb wait_d = req_ready_q ? 8'h00 : wait_q + 8'h01;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) wait_q <= 8'h00;
    else wait_q <= wait_d;
  end
  // ==========
  // reserved bit clear
  a_rsv_bit_zero: assert property (resp_valid_q |-> !resp_q.w0[11])
    else $error("reserved bit set in answer");
  a_err_no_commit: assert property (resp_valid_q && resp_q.w0[15:12] == 4'h7 |->
    !commit_q && resp_q.w3 == 16'h0000 && resp_q.w2[15:8] == 8'h00)
    else $error("error answer malformed or stored");
  a_unsupp_id: assert property (req_valid && req_ready_q && req.w0[15:12] == 4'h5 |=>
    resp_valid_q && resp_q.w0[15:12] == 4'h7 && resp_q.w2 == 16'h006A)
    else $error("unsupported id not refused at once");
  a_direct_num: assert property (req_valid && req_ready_q && req.w1[7:0] == 8'h00
    ##1 lookup_valid_q |-> lookup_num_q == {5'h00, $past(req.w0[10:0])})
    else $error("direct number not passed through");
  a_page_offset: assert property (req_valid && req_ready_q && req.w1[7:0] == 8'h74
    ##1 lookup_valid_q |-> lookup_num_q == {5'h00, $past(req.w0[10:0])} + 16'hEA60)
    else $error("page offset wrong");
  a_attr_answer: assert property (!req_ready_q && attr_valid |=> resp_valid_q && req_ready_q)
    else $error("no answer after attributes");
  a_commit_ok: assert property (commit_q |-> resp_valid_q && commit_val_q == lookup_val_q
    && resp_q.w0[15:12] inside {4'h1, 4'h2, 4'h4, 4'h5})
    else $error("store without positive answer");
  a_wait_bound: assert property (wait_q <= LOOKUP_CYCLES)
    else $error("lookup wait not bounded");
  c_commit: cover property (commit_q);
  c_timeout: cover property (resp_valid_q && resp_q.w2 == 16'h0011);
  c_fast_attr: cover property (lookup_valid_q && attr_valid);
endmodule
bind param_channel_error_and_page_index pchan_sva #(.LOOKUP_CYCLES(LOOKUP_CYCLES)) u_pchan_sva (
  .sys_clk, .sys_rst, .req_valid, .req, .req_ready_q, .lookup_valid_q, .lookup_num_q,
  .lookup_val_q, .attr_valid, .commit_q, .commit_val_q, .resp_valid_q, .resp_q);

// [tb.sv]
// self-checking bench for the parameter channel checker
`timescale 1ns/10ps
`include "pchan_regs.svh"
module tb;
  localparam logic [15:0] RQ = 16'h1064;
  localparam logic [15:0] CQ = 16'h2064;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  pchan_pkg::chan_t req = '0;
  pchan_pkg::attr_t attr, cfg, g, c;
  logic [4:0] dly = 5'h01;
  logic attr_valid, req_ready_q, lookup_valid_q, commit_q, resp_valid_q, cm;
  logic [15:0] lookup_num_q, reg_rdata_q, rd;
  logic [7:0] lookup_sub_q;
  logic [31:0] lookup_val_q, commit_val_q;
  pchan_pkg::chan_t resp_q;
  logic [63:0] rsp;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  int n_mismatch = 0;
  int check_count = 0;
  int ne = 0;
  logic [7:0] pg [8] = '{8'h00, 8'h80, 8'h90, 8'h20, 8'hA0, 8'h50, 8'hF0, 8'h74};
  logic [15:0] po [8] = '{16'h0000, 16'h07D0, 16'h1770, 16'h1F40, 16'h2710, 16'h4E20,
    16'h7530, 16'hEA60};
  always #25 sys_clk = ~sys_clk;
  // short lookup timeout keeps the run brief
  param_channel_error_and_page_index #(.LOOKUP_CYCLES(4)) u_param_channel_error_and_page_index (
    .sys_clk, .sys_rst, .req_valid, .req, .req_ready_q, .lookup_valid_q, .lookup_num_q,
    .lookup_sub_q, .lookup_val_q, .attr_valid, .attr, .commit_q, .commit_val_q,
    .resp_valid_q, .resp_q, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q);
  pchan_db_model u_pchan_db_model (
    .sys_clk, .sys_rst, .lookup_valid_q, .cfg, .dly, .attr_valid, .attr);
  // ==========
  // access tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata_q;
  endtask
  // one request, bounded wait for its answer
  task automatic send(input logic [15:0] w0, w1, w3);
    int i;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= {w0, w1, 16'h0000, w3};
    @(posedge sys_clk);
    req_valid <= 1'b0;
    for (i = 0; i < 40; i++) begin
      #1;
      if (resp_valid_q === 1'b1) break;
      @(posedge sys_clk);
    end
    if (i == 40) begin
      n_mismatch++;
      test_done();
    end
    rsp = resp_q;
    cm = commit_q;
  endtask
  // error case: control word, request, expected error number
  task automatic ec(input logic [15:0] ctl, w0, w1, w3, input logic [7:0] e);
    wr(`ADDR_CTRL, ctl);
    cfg = c;
    send(w0, w1, w3);
    ne++;
    chk(rsp, {4'h7, 1'b0, w0[10:0], w1, 8'h00, e, 16'h0000});
    chk({63'h0, cm}, 64'h0);
    c = g;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    g = '0;
    g.exists = 1'b1;
    g.listed = 1'b1;
    g.abs_max = 32'hFFFFFFFF;
    g.cur_max = 32'hFFFFFFFF;
    g.value_mask = 32'hFFFFFFFF;
    c = g;
    cfg = g;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rdr(`ADDR_CTRL);
    chk(rd, 16'h0001);
    rdr(`ADDR_COMM_SEL);
    chk(rd, 16'h0000);
    rdr(4'hF);
    chk(rd, 16'h0000);
    $display("test reset values done");
    ec(16'h0003, 16'h5064, 16'h0000, 16'h0000, 8'h6A);
    ec(16'h0003, RQ, 16'h0033, 16'h0000, 8'h87);
    ec(16'h0001, RQ, 16'h0033, 16'h0000, 8'h00);
    ec(16'h0001, 16'h17D0, 16'h0000, 16'h0000, 8'h00);
    c.exists = 1'b0;
    ec(16'h0001, RQ, 16'h0000, 16'h0000, 8'h00);
    c.deactivated = 1'b1;
    ec(16'h0001, RQ, 16'h0000, 16'h0000, 8'h65);
    ec(16'h0009, RQ, 16'h0000, 16'h0000, 8'h11);
    ec(16'h0001, RQ, 16'h0100, 16'h0000, 8'h04);
    c.indexed = 1'b1;
    c.sub_count = 8'h02;
    ec(16'h0001, RQ, 16'h0200, 16'h0000, 8'h03);
    chk(lookup_sub_q, 8'h02);
    c.desc_fixed = 1'b1;
    ec(16'h0001, CQ, 16'h0000, 16'h0000, 8'h07);
    c.read_only = 1'b1;
    ec(16'h0001, CQ, 16'h0000, 16'h0000, 8'h01);
    ec(16'h0000, CQ, 16'h0000, 16'h0000, 8'h0B);
    c.commission_only = 1'b1;
    ec(16'h0001, CQ, 16'h0000, 16'h0000, 8'h86);
    c.loop_locked = 1'b1;
    ec(16'h0005, CQ, 16'h0000, 16'h0000, 8'h6B);
    c.needs_code = 1'b1;
    ec(16'h0001, CQ, 16'h0000, 16'h0000, 8'hCC);
    c.is_dword = 1'b1;
    ec(16'h0001, CQ, 16'h0000, 16'h0000, 8'h05);
    c.reset_only = 1'b1;
    ec(16'h0001, CQ, 16'h0000, 16'h0001, 8'h06);
    c.abs_max = 32'h00000010;
    ec(16'h0001, CQ, 16'h0000, 16'h0011, 8'h02);
    c.cur_min = 32'h00000005;
    ec(16'h0001, CQ, 16'h0000, 16'h0004, 8'hC8);
    c.cur_max = 32'h00000005;
    ec(16'h0001, CQ, 16'h0000, 16'h0006, 8'hC9);
    c.discrete = 1'b1;
    c.listed = 1'b0;
    ec(16'h0001, CQ, 16'h0000, 16'h0000, 8'h14);
    c.value_mask = 32'h0000000F;
    ec(16'h0001, CQ, 16'h0000, 16'h0010, 8'h68);
    c.is_dword = 1'b1;
    ec(16'h0041, RQ, 16'h0000, 16'h0000, 8'h66);
    dly = 5'h1F;
    ec(16'h0001, RQ, 16'h0000, 16'h0000, 8'h11);
    $display("test error numbers done");
    // selector at commissioning value lets the write through
    dly = 5'h00;
    wr(`ADDR_COMM_SEL, 16'h000F);
    c.commission_only = 1'b1;
    cfg = c;
    send(CQ, 16'h0000, 16'h001A);
    chk({rsp[63:48], rsp[31:0]}, {16'h1064, 32'h0000001A});
    chk({cm, commit_val_q}, {1'b1, 32'h0000001A});
    cfg = g;
    // top number of every page, answers slow and fast
    for (int k = 0; k < 8; k++) begin
      dly = 5'(k % 3);
      send(16'h17CF, {8'h00, pg[k]}, 16'h0000);
      chk(rsp[63:48], 16'h17CF);
      chk(lookup_num_q, po[k] + 16'h07CF);
    end
    send(16'h0064, 16'h0000, 16'h0000);
    chk(rsp, 64'h0);
    $display("test page index done");
    rdr(`ADDR_ERR_CNT);
    chk(rd, 16'(ne));
    rdr(`ADDR_REQ_CNT);
    chk(rd, 16'(ne + 10));
    wr(`ADDR_ERR_CNT, 16'h0000);
    rdr(`ADDR_ERR_CNT);
    chk(rd, 16'h0000);
    $display("test counters done");
    test_done();
  end
endmodule
